// >>> design/fpr_ctrl.sv
// Fuse programmer controller with Wishbone register port
//
// The register addresses and register access over Wishbone are this design's own decisions.
module fpr_ctrl #(
  parameter int T1_CYC   = fpr_pkg::T1_CYC,
  parameter int GAP_CYC  = fpr_pkg::GAP_CYC,
  parameter int BLOW_CYC = fpr_pkg::BLOW_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        filter_or_readback_pin_i,
  output logic             serial_pulse_input_o
);
  import fpr_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_SEND  = 3'b001,
    S_BLOW  = 3'b010,
    S_RPULS = 3'b011
  } fpr_st_e;

  fpr_st_e                st_r, st_nxt;
  fpr_cmd_s               cmd_r, cmd_nxt;
  logic [PKT_BITS-1:0]    sh_r, sh_nxt;
  logic [5:0]             bcnt_r, bcnt_nxt;
  logic [3:0]             rcnt_r, rcnt_nxt;
  logic [TMR_W-1:0]       tmr_r, tmr_nxt;
  logic [7:0]             rdata_r, rdata_nxt;
  logic                   refused_r, refused_nxt;
  logic                   low_sense_r, low_sense_nxt;
  logic                   master_r, master_nxt;
  logic [3:0][7:0]        tried_r, tried_nxt;
  logic [3:0][7:0]        rb_r, rb_nxt;
  logic [31:0]            dat_nxt;
  logic                   ack_nxt;
  logic                   p_start, p_idle, p_done;
  logic                   req, wr_cmd, wr_stat, prog_ok;
  fpr_cmd_s               new_cmd;
  logic                   code_xor, comb_par, par_err;
  logic [3:0]             rb_hit;

  fpr_pulse #(
    .T1_CYC  (T1_CYC),
    .GAP_CYC (GAP_CYC)
  ) u_pulse (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (p_start),
    .bit_i   (sh_r[PKT_BITS-1]),
    .idle_o  (p_idle),
    .pin_o   (serial_pulse_input_o),
    .done_o  (p_done)
  );

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  assign req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_cmd  = req && wb_we_i && wb_adr_i == ADR_CMD &&
                   wb_sel_i == 4'hF && wb_dat_i[CMD_GO_BIT];
  assign wr_stat = req && wb_we_i && wb_adr_i == ADR_STATUS &&
                   wb_sel_i[0] && wb_dat_i[ST_REFUSED];
  assign new_cmd = fpr_cmd_s'(wb_dat_i[11:0]);

  // One fuse per packet, never twice, nothing after master [RULE17]
  assign prog_ok = $onehot(new_cmd.value) && !master_r &&
                   ((tried_r[new_cmd.param] & new_cmd.value) == 8'h00) &&
                   (new_cmd.param != PAR_OTHER ||
                    (new_cmd.value & ~(OTHER_MASTER | OTHER_PARITY)) == 8'h00);

  // Expected device parity from the read-back codes
  assign code_xor = ^{rb_r[0][2:0], rb_r[1][6:0], rb_r[2]}; // [RULE4]
  assign comb_par = code_xor ^ rb_r[3][2];                  // [RULE5] [RULE23]
  assign par_err  = rb_r[3][0] & comb_par;                  // [RULE1] [RULE2]

  generate
    for (genvar g = 0; g < 4; g++) begin : g_rb
      assign rb_hit[g] = (wb_adr_i == ADR_RB0 + 8'(4 * g));
    end
  endgenerate

  // Wait out the done cycle so the emitter sees the shifted bit
  assign p_start = (st_r == S_SEND || st_r == S_RPULS) && p_idle && !p_done;

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt        = st_r;
    cmd_nxt       = cmd_r;
    sh_nxt        = sh_r;
    bcnt_nxt      = bcnt_r;
    rcnt_nxt      = rcnt_r;
    tmr_nxt       = tmr_r;
    rdata_nxt     = rdata_r;
    refused_nxt   = refused_r && !wr_stat;
    low_sense_nxt = low_sense_r;
    master_nxt    = master_r;
    tried_nxt     = tried_r;
    rb_nxt        = rb_r;
    unique case (st_r)
      S_IDLE: begin
        if (wr_cmd) begin
          if (new_cmd.func == FN_PROG && !prog_ok) begin
            refused_nxt = 1'b1;
          end else begin
            cmd_nxt  = new_cmd;
            // Framed packet, MSB of each field first [RULE20] [RULE6]
            sh_nxt   = {PKT_START, new_cmd.func, new_cmd.param,
                        PKT_DUMMY, new_cmd.value, PKT_END};
            bcnt_nxt = '0;
            st_nxt   = S_SEND;
            if (new_cmd.func == FN_PROG) begin
              tried_nxt[new_cmd.param] = tried_r[new_cmd.param] |
                                         new_cmd.value; // [RULE17]
              // Master blown last, locks out programming [RULE16] [RULE18]
              if (new_cmd.param == PAR_OTHER && new_cmd.value == OTHER_MASTER)
                master_nxt = 1'b1;
            end
          end
        end
      end
      S_SEND: begin
        if (p_done) begin
          sh_nxt   = {sh_r[PKT_BITS-2:0], 1'b0};
          bcnt_nxt = bcnt_r + 6'h01;
          if (bcnt_r == 6'(PKT_BITS - 1)) begin
            tmr_nxt = '0;
            if (cmd_r.func == FN_READ) begin
              // MSB already on the pin after entry [RULE7] [RULE11]
              rdata_nxt = {rdata_r[6:0], filter_or_readback_pin_i};
              rcnt_nxt  = 4'h1;
              st_nxt    = S_RPULS;
            end else if (cmd_r.func == FN_PROG) begin
              st_nxt = S_BLOW;
            end else begin
              if (cmd_r.func == FN_SENSE && cmd_r.param == 2'h0)
                low_sense_nxt = cmd_r.value[0]; // [RULE12] [RULE13]
              st_nxt = S_IDLE;
            end
          end
        end
      end
      S_BLOW: begin
        tmr_nxt = tmr_r + TMR_W'(1);
        if (tmr_r == TMR_W'(BLOW_CYC - 1))
          st_nxt = S_IDLE;
      end
      S_RPULS: begin
        if (p_done) begin
          if (rcnt_r < 4'(READ_BITS)) begin
            // Each falling edge brings the next bit [RULE8] [RULE10]
            rdata_nxt = {rdata_r[6:0], filter_or_readback_pin_i};
            rcnt_nxt  = rcnt_r + 4'h1;
          end else begin
            // Eighth pulse closes read mode [RULE9]
            rb_nxt[cmd_r.param] = rdata_r;
            st_nxt = S_IDLE;
          end
        end
      end
      default: st_nxt = S_IDLE;
    endcase
    if (wr_cmd && st_r != S_IDLE)
      refused_nxt = 1'b1;
  end

  // ---------------------------------------------------------------
  // Bus answer
  // ---------------------------------------------------------------
  always_comb begin
    ack_nxt = req;
    dat_nxt = 32'h0000_0000;
    if (req && !wb_we_i) begin
      if (wb_adr_i == ADR_CMD) begin
        dat_nxt[11:0] = cmd_r;
      end else if (wb_adr_i == ADR_STATUS) begin
        dat_nxt[ST_BUSY]      = (st_r != S_IDLE);
        dat_nxt[ST_REFUSED]   = refused_r;
        dat_nxt[ST_LOW_SENSE] = low_sense_r; // [RULE14] [RULE19]
        dat_nxt[ST_MASTER]    = master_r;
        dat_nxt[ST_CODE_XOR]  = code_xor;
        dat_nxt[ST_COMB_PAR]  = comb_par;
        dat_nxt[ST_PAR_ERR]   = par_err;     // [RULE3]
      end else if (wb_adr_i == ADR_RDATA) begin
        dat_nxt[7:0] = rdata_r;
      end else begin
        for (int i = 0; i < 4; i++)
          if (rb_hit[i]) dat_nxt[7:0] = rb_r[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r        <= S_IDLE;
      cmd_r       <= '0;
      sh_r        <= '0;
      bcnt_r      <= '0;
      rcnt_r      <= '0;
      tmr_r       <= '0;
      rdata_r     <= '0;
      refused_r   <= 1'b0;
      low_sense_r <= 1'b0; // [RULE15]
      master_r    <= 1'b0;
      tried_r     <= '0;
      rb_r        <= '0;
      wb_ack_o    <= 1'b0;
      wb_dat_o    <= '0;
    end else begin
      st_r        <= st_nxt;
      cmd_r       <= cmd_nxt;
      sh_r        <= sh_nxt;
      bcnt_r      <= bcnt_nxt;
      rcnt_r      <= rcnt_nxt;
      tmr_r       <= tmr_nxt;
      rdata_r     <= rdata_nxt;
      refused_r   <= refused_nxt;
      low_sense_r <= low_sense_nxt;
      master_r    <= master_nxt;
      tried_r     <= tried_nxt;
      rb_r        <= rb_nxt;
      wb_ack_o    <= ack_nxt;
      wb_dat_o    <= dat_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_last_bit;
    st_r == S_SEND && p_done && bcnt_r == 6'(PKT_BITS - 1);
  endsequence

  sequence s_read_close;
    st_r == S_RPULS && p_done && rcnt_r == 4'(READ_BITS);
  endsequence

  AST_ACK_PULSE: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single cycle");

  AST_PKT_FRAME: assert property ( // [RULE20]
    @(posedge clk_i) disable iff (rst_i)
    st_r == S_IDLE && wr_cmd && !(new_cmd.func == FN_PROG && !prog_ok)
    |=> st_r == S_SEND && sh_r[37:26] == PKT_START && sh_r[11:0] == PKT_END)
    else $error("packet frame not loaded");

  AST_READ_ENTRY: assert property ( // [RULE6] [RULE7]
    @(posedge clk_i) disable iff (rst_i)
    s_last_bit and cmd_r.func == FN_READ |=> st_r == S_RPULS && rcnt_r == 4'h1)
    else $error("read mode not entered after read packet");

  AST_READ_CLOSE: assert property ( // [RULE8] [RULE9]
    @(posedge clk_i) disable iff (rst_i)
    s_read_close |=> st_r == S_IDLE && rb_r[cmd_r.param] == $past(rdata_r))
    else $error("read did not close after eighth pulse");

  AST_SENSE_SET: assert property ( // [RULE12] [RULE13]
    @(posedge clk_i) disable iff (rst_i)
    s_last_bit and cmd_r.func == FN_SENSE && cmd_r.param == 2'h0
    |=> low_sense_r == cmd_r.value[0])
    else $error("sense current state not updated");

  AST_NO_RETRY: assert property ( // [RULE17]
    @(posedge clk_i) disable iff (rst_i)
    st_r == S_IDLE && wr_cmd && new_cmd.func == FN_PROG &&
    (tried_r[new_cmd.param] & new_cmd.value) != 8'h00
    |=> st_r == S_IDLE && refused_r)
    else $error("repeat fuse attempt not refused");

  AST_MASTER_LAST: assert property ( // [RULE16] [RULE18]
    @(posedge clk_i) disable iff (rst_i)
    master_r && st_r == S_IDLE && wr_cmd && new_cmd.func == FN_PROG
    |=> st_r == S_IDLE ##1 st_r == S_IDLE)
    else $error("programming after master fuse");

  AST_BLOW_WAIT: assert property (
    @(posedge clk_i) disable iff (rst_i)
    s_last_bit and cmd_r.func == FN_PROG |=> st_r == S_BLOW [*8])
    else $error("blow wait cut short");

  AST_PARITY: assert property ( // [RULE1] [RULE2] [RULE5]
    @(posedge clk_i) disable iff (rst_i)
    par_err == (rb_r[3][0] &&
      ((^rb_r[0][2:0]) ^ (^rb_r[1][6:0]) ^ (^rb_r[2]) ^ rb_r[3][2])))
    else $error("predicted parity error inconsistent");
endmodule : fpr_ctrl

// >>> design/fpr_pulse.sv
// Width-coded pulse emitter for the single-wire serial input
module fpr_pulse #(
  parameter int T1_CYC  = fpr_pkg::T1_CYC,
  parameter int GAP_CYC = fpr_pkg::GAP_CYC
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic start_i,
  input  wire logic bit_i,
  output logic      idle_o,
  output logic      pin_o,
  output logic      done_o
);
  import fpr_pkg::*;

  typedef enum logic [1:0] {
    P_IDLE = 2'b00,
    P_HIGH = 2'b01,
    P_GAP  = 2'b10
  } fpr_pst_e;

  fpr_pst_e          st_r, st_nxt;
  logic [TMR_W-1:0]  cnt_r, cnt_nxt;
  logic              bit_r, bit_nxt;
  logic              pin_nxt, done_nxt;
  logic [TMR_W-1:0]  width;

  assign width = bit_r ? TMR_W'(T1_CYC - 1) : TMR_W'(T0_CYC - 1);

  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r + TMR_W'(1);
    bit_nxt  = bit_r;
    pin_nxt  = pin_o;
    done_nxt = 1'b0;
    unique case (st_r)
      P_IDLE: begin
        cnt_nxt = '0;
        if (start_i) begin
          bit_nxt = bit_i;
          pin_nxt = 1'b1;
          st_nxt  = P_HIGH;
        end
      end
      P_HIGH: begin
        // Width picks the shifted value [RULE21] [RULE22]
        if (cnt_r == width) begin
          pin_nxt = 1'b0;
          cnt_nxt = '0;
          st_nxt  = P_GAP;
        end
      end
      P_GAP: begin
        // Gap before the next pulse [RULE22]
        if (cnt_r == TMR_W'(GAP_CYC - 1)) begin
          done_nxt = 1'b1;
          st_nxt   = P_IDLE;
        end
      end
      default: st_nxt = P_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r   <= P_IDLE;
      cnt_r  <= '0;
      bit_r  <= 1'b0;
      pin_o  <= 1'b0;
      done_o <= 1'b0;
      idle_o <= 1'b1;
    end else begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      bit_r  <= bit_nxt;
      pin_o  <= pin_nxt;
      done_o <= done_nxt;
      idle_o <= (st_nxt == P_IDLE);
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic [TMR_W-1:0] hi_cnt_r;
  always_ff @(posedge clk_i) begin
    if (rst_i || !pin_o) hi_cnt_r <= '0;
    else                 hi_cnt_r <= hi_cnt_r + TMR_W'(1);
  end

  AST_PULSE_WIDTH: assert property ( // [RULE21] [RULE22]
    @(posedge clk_i) disable iff (rst_i)
    $fell(pin_o) |-> (hi_cnt_r == (bit_r ? TMR_W'(T1_CYC) : TMR_W'(T0_CYC))))
    else $error("pulse width wrong for coded bit");
endmodule : fpr_pulse

// >>> dv/fpr_dev_model.sv
// Behavioural model of the amplifier fuse bank and serial decoder
module fpr_dev_model #(
  parameter int         T1_CYC    = 300,
  parameter logic [7:0] WEAK_MASK = 8'h00
) (
  input  wire logic clk_i,
  input  wire logic por_i,
  input  wire logic serial_pulse_input_i,
  output logic      filter_or_readback_pin_o
);
  import fpr_pkg::*;
  localparam logic [7:0] USED [4] = '{8'h07, 8'h7F, 8'hFF, 8'h07};
  logic [7:0]  fuse [4];
  logic [7:0]  sensed [4];
  logic [37:0] in_sr;
  logic [37:0] nxt;
  logic [7:0]  rb_sr;
  logic        low_sense;
  logic        rd_mode;
  logic        pin_d;
  logic        tog;
  logic        code_xor;
  logic        comb_par;
  logic        par_err;
  logic        amp_out;
  int          width;
  int          rd_cnt;

  always_comb begin
    for (int p = 0; p < 4; p++) begin
      sensed[p] = fuse[p] & USED[p] & ~(low_sense ? WEAK_MASK : 8'h00);
    end
    code_xor = ^{sensed[0][2:0], sensed[1][6:0], sensed[2]};
    comb_par = code_xor ^ sensed[3][2];
    par_err  = sensed[3][0] & comb_par;
    amp_out  = rd_mode ? rb_sr[7] : !par_err;
    // Idle pin carries analog level, shown as a toggling pattern
    filter_or_readback_pin_o = rd_mode ? rb_sr[7] : tog;
  end

  always @(posedge clk_i) begin
    pin_d <= serial_pulse_input_i;
    tog   <= ~tog;
    if (por_i) begin
      in_sr     <= '0;
      width     <= 0;
      rd_mode   <= 1'b0;
      rd_cnt    <= 0;
      rb_sr     <= '0;
      tog       <= 1'b0;
      low_sense <= 1'b0;
      fuse      <= '{default: 8'h00};
    end else if (serial_pulse_input_i) begin
      width <= width + 1;
    end else if (pin_d) begin
      width <= 0;
      if (rd_mode) begin
        rb_sr   <= {rb_sr[6:0], 1'b0};
        rd_cnt  <= rd_cnt + 1;
        rd_mode <= (rd_cnt < 7);
      end else if (width >= 13) begin
        nxt = {in_sr[36:0], width >= T1_CYC};
        in_sr <= nxt;
        if (nxt[37:26] == PKT_START && nxt[21:20] == PKT_DUMMY &&
            nxt[11:0] == PKT_END) begin
          case (nxt[25:24])
            FN_SENSE: if (nxt[23:22] == 2'h0) low_sense <= nxt[12];
            FN_PROG: if (!fuse[3][0]) fuse[nxt[23:22]] <= fuse[nxt[23:22]] | nxt[19:12];
            FN_READ: begin
              rd_mode <= 1'b1;
              rd_cnt  <= 0;
              rb_sr   <= sensed[nxt[23:22]];
            end
            default: ;
          endcase
        end
      end
    end
  end
endmodule : fpr_dev_model

// >>> dv/test_fpr_ctrl.sv
// Self-checking bench for the fuse programmer controller
module test_fpr_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import fpr_pkg::*;
  localparam int T1 = 300;
  logic        clk_i    = 1'b0;
  logic        rst_i    = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i  = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        pin;
  logic        ser;
  logic [31:0] st;
  int          mismatches = 0;
  int          checks     = 0;

  fpr_ctrl #(.T1_CYC(T1), .GAP_CYC(20), .BLOW_CYC(50)) fpr_ctrl_i (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .filter_or_readback_pin_i(pin),
    .serial_pulse_input_o(ser));
  fpr_dev_model #(.T1_CYC(T1)) fpr_dev_model_i (
    .clk_i, .por_i(rst_i), .serial_pulse_input_i(ser),
    .filter_or_readback_pin_o(pin));

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  task automatic test_done();
    if (mismatches == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %0t: word %h want %h", $time, got, exp);
    end
  endtask : cmp_word

  task automatic cmp_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %0t: bit %b want %b", $time, got, exp);
    end
  endtask : cmp_bit

  // Classic cycle; read data lands in st
  task automatic bus(input logic we, input logic [7:0] adr,
                     input logic [31:0] dat, input logic [3:0] sel);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= dat;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    st = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : bus

  task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
    bus(1'b0, adr, 32'h0, 4'hF);
    cmp_word(st, exp);
  endtask : rd

  // Issue a command and poll until the controller is idle
  task automatic cmd(input logic [1:0] fn, input logic [1:0] p,
                     input logic [7:0] v);
    bus(1'b1, ADR_CMD, {1'b1, 19'h0, fn, p, v}, 4'hF);
    do begin
      bus(1'b0, ADR_STATUS, 32'h0, 4'hF);
    end while (st[ST_BUSY] !== 1'b0);
  endtask : cmd

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    rd(ADR_STATUS, 32'h0);
    rd(ADR_RB0, 32'h0);
    rd(8'hFC, 32'h0);
    cmp_bit(fpr_dev_model_i.low_sense, 1'b0);
    // Command word with a missing byte select must be ignored
    bus(1'b1, ADR_CMD, {1'b1, 19'h0, FN_SENSE, 2'h0, 8'h01}, 4'h7);
    rd(ADR_STATUS, 32'h0);
  endtask : t_reset

  // Upper value bits set opposite to the LSB
  task automatic t_sense(input logic lo);
    cmd(FN_SENSE, 2'h0, {{7{~lo}}, lo});
    cmp_bit(st[ST_LOW_SENSE], lo);
    cmp_bit(fpr_dev_model_i.low_sense, lo);
  endtask : t_sense

  task automatic t_prog();
    cmd(FN_PROG, 2'h0, 8'h04);
    cmp_word({24'h0, fpr_dev_model_i.fuse[0]}, 32'h4);
    cmp_bit(fpr_dev_model_i.code_xor, 1'b1);
    cmp_bit(fpr_dev_model_i.par_err, 1'b0);
    cmd(FN_PROG, 2'h0, 8'h04);
    cmp_bit(st[ST_REFUSED], 1'b1);
    bus(1'b1, ADR_STATUS, 32'h2, 4'h1);
    rd(ADR_STATUS, 32'h4);
  endtask : t_prog

  // Read under low sense current, junk in the ignored value field
  task automatic t_read();
    cmd(FN_READ, 2'h0, 8'hA5);
    rd(ADR_RB0, 32'h4);
    rd(ADR_RDATA, 32'h4);
    rd(ADR_RB0 + 8'h04, 32'h0);
    rd(ADR_STATUS, 32'h34);
    cmp_bit(fpr_dev_model_i.rd_mode, 1'b0);
  endtask : t_read

  task automatic t_master();
    cmd(FN_PROG, PAR_OTHER, OTHER_MASTER);
    cmp_bit(st[ST_MASTER], 1'b1);
    cmp_bit(fpr_dev_model_i.par_err, 1'b1);
    cmp_bit(fpr_dev_model_i.amp_out, 1'b0);
    cmd(FN_PROG, 2'h1, 8'h01);
    cmp_bit(st[ST_REFUSED], 1'b1);
    cmp_word({24'h0, fpr_dev_model_i.fuse[1]}, 32'h0);
    // Read back the other-functions fuses under high sense current
    cmd(FN_READ, PAR_OTHER, 8'h00);
    rd(ADR_RB0 + 8'h0C, 32'h1);
    rd(ADR_STATUS, 32'h7A);
  endtask : t_master

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_sense(1'b1);
    t_prog();
    t_read();
    t_sense(1'b0);
    t_master();
    test_done();
  end

  initial begin
    #400us;
    mismatches++;
    $display("mismatch %0t: timeout", $time);
    test_done();
  end
endmodule : test_fpr_ctrl

// >>> inc/fpr_pkg.sv
// Constants and types for the fuse programmer controller
//
// Behaviour
// (RULE1) Unblown master fuse forces parity error low
// (RULE2) Blown master fuse passes combined parity through
// (RULE3) Parity error pulls amplifier output low
// (RULE4) Code parity is XOR of 18 code bits
// (RULE5) Combined parity is code parity XOR parity fuse
// (RULE6) Function 11 packet enters read, value ignored
// (RULE7) Read loads parameter, MSB on readback pin
// (RULE8) Falling edges shift readback, seven more pulses
// (RULE9) Eighth pulse after entry ends read mode
// (RULE10) Short parameters read back zero-padded at top
// (RULE11) Amplifier output mirrors readback bits in read
// (RULE12) Sense packet value LSB 1 selects low current
// (RULE13) Sense packet value LSB 0 restores high current
// (RULE14) Low sense current is four times lower
// (RULE15) Sense selection volatile, high after power-up
// (RULE16) Program other-functions value 01 blows master fuse
// (RULE17) Never retry a fuse already attempted
// (RULE18) Codes first, parity next, master fuse last
// (RULE19) Verify with low then high sense current
// (RULE20) 38-bit packet with fixed start and end fields
// (RULE21) Short pulse shifts in a zero
// (RULE22) Long pulse shifts in a one, gap between pulses
// (RULE23) Parity and master fuse values feed parity check
package fpr_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADR_CMD    = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_RDATA  = 8'h08;
  localparam logic [7:0] ADR_RB0    = 8'h10;
  localparam int CMD_GO_BIT   = 31;
  localparam int ST_BUSY      = 0;
  localparam int ST_REFUSED   = 1;
  localparam int ST_LOW_SENSE = 2;
  localparam int ST_MASTER    = 3;
  localparam int ST_CODE_XOR  = 4;
  localparam int ST_COMB_PAR  = 5;
  localparam int ST_PAR_ERR   = 6;
  // ---------------------------------------------------------------
  // Packet fields
  // ---------------------------------------------------------------
  localparam logic [11:0] PKT_START = 12'h801;
  localparam logic [11:0] PKT_END   = 12'h7FE;
  localparam logic [1:0]  PKT_DUMMY = 2'h2;
  localparam int          PKT_BITS  = 38;
  localparam logic [1:0] FN_SENSE = 2'h0;
  localparam logic [1:0] FN_SIM   = 2'h1;
  localparam logic [1:0] FN_PROG  = 2'h2;
  localparam logic [1:0] FN_READ  = 2'h3;
  localparam logic [1:0] PAR_OTHER = 2'h3;
  localparam logic [7:0] OTHER_MASTER = 8'h01;
  localparam logic [7:0] OTHER_PARITY = 8'h04;
  localparam int READ_BITS = 8;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ    = 250;
  localparam int T0_NS      = 1000;
  localparam int T0_CYC     = (T0_NS * CLK_MHZ + 999) / 1000;
  localparam int T1_MIN_US  = 50;
  localparam int T1_CYC     = T1_MIN_US * CLK_MHZ;
  localparam int GAP_MIN_US = 10;
  localparam int GAP_CYC    = GAP_MIN_US * CLK_MHZ;
  localparam int BLOW_MS    = 1;
  localparam int BLOW_CYC   = BLOW_MS * 1000 * CLK_MHZ;
  localparam int TMR_W      = 20;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0] func;
    logic [1:0] param;
    logic [7:0] value;
  } fpr_cmd_s;
endpackage : fpr_pkg
